// ### rtl/slem_map.vh
// register offsets, field positions, reset values and lane count of the lane error monitor
`ifndef SLEM_MAP_VH
`define SLEM_MAP_VH
// word indices; byte address is four times the index
`define SLEM_IDX_CNT_SEL      12'h46b
`define SLEM_IDX_DESKEW       12'h46c
`define SLEM_IDX_DISP         12'h46d
`define SLEM_IDX_INVALID      12'h46e
`define SLEM_IDX_UNEXP        12'h46f
`define SLEM_IDX_SYNC         12'h470
`define SLEM_IDX_IRQ_ENABLE   12'h47a
`define SLEM_IDX_THRESHOLD    12'h47c
`define SLEM_IDX_IRQ_STATUS   12'h480
// fields
`define SLEM_TYPE_DISP        2'h0
`define SLEM_TYPE_INVALID     2'h1
`define SLEM_TYPE_UNEXP       2'h2
`define SLEM_BIT_IRQ_CLR      7
`define SLEM_BIT_CNT_STOP     6
`define SLEM_BIT_CNT_CLR      5
`define SLEM_BIT_MASK_DISP    7
`define SLEM_BIT_MASK_INVALID 6
`define SLEM_BIT_MASK_UNEXP   5
`define SLEM_BIT_MASK_SYNC    0
// reset values and lane count
`define SLEM_RST_DESKEW       8'h0f
`define SLEM_RST_THRESHOLD    8'hff
`define SLEM_LANES            8
`endif

// ### rtl/slem_lane_error_monitor.v
// per-lane code group error monitor with avalon-mm register slave
`timescale 1ns/1ns
`include "slem_map.vh"
// What this block does
// - type code 00 disparity, 01 invalid, 10 control
// - readback returns the count of the selected error type and lane
// - lane selector bits 6:4 pick readback lane
// - deskew enable register, low four set
// - disparity flag sets when count reaches threshold
// - command bit 7 clears disparity interrupt
// - command bit 6 stops disparity counter
// - command bit 5 zeroes disparity counter
// - bits 2:0 name the commanded lane
// - invalid code flag sets at threshold
// - invalid and control commands: clear, stop, zero
// - unexpected control flag sets at threshold
// - sync status shows live lane alignment
// - writing bit 7 clears sync interrupt
// - any lost alignment raises sync request
// - masked disparity threshold drives interrupt low
module slem_lane_error_monitor (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_b_in,
  // avalon-mm slave
  input  wire [13:0] avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  output reg  [1:0]  avs_response_out,
  // link side, sampled on the reference clock
  input  wire        link_clk_in,
  input  wire [7:0]  disparity_error_in,
  input  wire [7:0]  invalid_code_in,
  input  wire [7:0]  unexpected_control_in,
  input  wire [7:0]  lane_alignment_flag_in,
  // outputs
  output reg  [7:0]  lane_align_enable_out,
  output reg         sync_request_b_out,
  output reg         irq_b_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_ACK  = 2'b10;

  integer i;

  // link clock and alignment pins pass three flops
  reg  [2:0]  lclk_sync;
  reg  [7:0]  al_s1;
  reg  [7:0]  al_s2;
  reg  [7:0]  al_s3;
  reg  [7:0]  lane_alignment_flag;
  reg         lclk_level;
  reg  [23:0] err_d1;
  reg  [23:0] err_d2;
  reg  [23:0] err_d3;
  // error levels count only once the second and third flops agree
  reg  [23:0] err_level;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lclk_sync  <= 3'h0;
      lclk_level <= 1'b0;
      al_s1      <= 8'h00;
      al_s2      <= 8'h00;
      al_s3      <= 8'h00;
      lane_alignment_flag <= 8'h00;
      err_d1     <= 24'h000000;
      err_d2     <= 24'h000000;
      err_d3     <= 24'h000000;
      err_level  <= 24'h000000;
    end else begin
      lclk_sync  <= {lclk_sync[1:0], link_clk_in};
      if (lclk_sync[1] == lclk_sync[2])
        lclk_level <= lclk_sync[2];
      al_s1 <= lane_alignment_flag_in;
      al_s2 <= al_s1;
      al_s3 <= al_s2;
      for (i = 0; i < `SLEM_LANES; i = i + 1) begin
        if (al_s2[i] == al_s3[i])
          lane_alignment_flag[i] <= al_s3[i];
      end
      err_d1 <= {unexpected_control_in, invalid_code_in, disparity_error_in};
      err_d2 <= err_d1;
      err_d3 <= err_d2;
      for (i = 0; i < 24; i = i + 1) begin
        if (err_d2[i] == err_d3[i])
          err_level[i] <= err_d3[i];
      end
    end
  end

  // one error sample per link clock rising edge, taken after the agreed edge
  reg lclk_prev;
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      lclk_prev <= 1'b0;
    else
      lclk_prev <= lclk_level;
  end
  wire link_tick = lclk_level & ~lclk_prev;

  // register file
  reg [1:0]  error_type_selector;
  reg [2:0]  readback_lane_selector;
  reg [7:0]  error_count_threshold;
  reg [7:0]  irq_enable;
  // counts are eight lanes of eight bits, lane 0 in the low byte
  wire [63:0] disparity_error_count;
  wire [63:0] invalid_code_count;
  wire [63:0] unexpected_control_count;
  wire [7:0]  disparity_error_flag;
  wire [7:0]  invalid_code_flag;
  wire [7:0]  unexpected_control_flag;
  reg [7:0]  sync_irq;
  reg [7:0]  sync_prev;
  reg [1:0]  state;

  wire [11:0] idx     = avs_address_in[13:2];
  wire        wr_go   = (state == ST_IDLE) & avs_write_in & avs_byteenable_in[0];
  wire [7:0]  wd      = avs_writedata_in[7:0];
  wire [2:0]  cmd_ln  = wd[2:0];

  // command pulses live for the accepting cycle only
  reg [2:0]  cmd_hit;
  always @* begin
    cmd_hit = 3'h0;
    if (wr_go) begin
      cmd_hit[0] = (idx == `SLEM_IDX_DISP);
      cmd_hit[1] = (idx == `SLEM_IDX_INVALID);
      cmd_hit[2] = (idx == `SLEM_IDX_UNEXP);
    end
  end

  // one-hot lane decode of a command write
  wire [7:0]  cmd_lane_hot = 8'h01 << cmd_ln;

  // per-type command pulses, alive in the accepting cycle only
  wire        disparity_irq_clear              = cmd_hit[0] & wd[`SLEM_BIT_IRQ_CLR];
  wire        disparity_counter_stop           = cmd_hit[0] & wd[`SLEM_BIT_CNT_STOP];
  wire        disparity_counter_clear          = cmd_hit[0] & wd[`SLEM_BIT_CNT_CLR];
  wire        invalid_code_irq_clear           = cmd_hit[1] & wd[`SLEM_BIT_IRQ_CLR];
  wire        invalid_code_counter_stop        = cmd_hit[1] & wd[`SLEM_BIT_CNT_STOP];
  wire        invalid_code_counter_clear       = cmd_hit[1] & wd[`SLEM_BIT_CNT_CLR];
  wire        unexpected_control_irq_clear     = cmd_hit[2] & wd[`SLEM_BIT_IRQ_CLR];
  wire        unexpected_control_counter_stop  = cmd_hit[2] & wd[`SLEM_BIT_CNT_STOP];
  wire        unexpected_control_counter_clear = cmd_hit[2] & wd[`SLEM_BIT_CNT_CLR];

  // one counter per lane and error type
  genvar g;
  generate
    for (g = 0; g < `SLEM_LANES; g = g + 1) begin : lane_g
      slem_err_counter disp_u (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .tick_in      (link_tick),
        .err_in       (err_level[g]),
        .clear_in     (disparity_counter_clear & cmd_lane_hot[g]),
        .stop_in      (disparity_counter_stop & cmd_lane_hot[g]),
        .irq_clear_in (disparity_irq_clear & cmd_lane_hot[g]),
        .threshold_in (error_count_threshold),
        .count_out    (disparity_error_count[g*8 +: 8]),
        .flag_out     (disparity_error_flag[g])
      );
      slem_err_counter inv_u (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .tick_in      (link_tick),
        .err_in       (err_level[8+g]),
        .clear_in     (invalid_code_counter_clear & cmd_lane_hot[g]),
        .stop_in      (invalid_code_counter_stop & cmd_lane_hot[g]),
        .irq_clear_in (invalid_code_irq_clear & cmd_lane_hot[g]),
        .threshold_in (error_count_threshold),
        .count_out    (invalid_code_count[g*8 +: 8]),
        .flag_out     (invalid_code_flag[g])
      );
      slem_err_counter unexp_u (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .tick_in      (link_tick),
        .err_in       (err_level[16+g]),
        .clear_in     (unexpected_control_counter_clear & cmd_lane_hot[g]),
        .stop_in      (unexpected_control_counter_stop & cmd_lane_hot[g]),
        .irq_clear_in (unexpected_control_irq_clear & cmd_lane_hot[g]),
        .threshold_in (error_count_threshold),
        .count_out    (unexpected_control_count[g*8 +: 8]),
        .flag_out     (unexpected_control_flag[g])
      );
    end
  endgenerate

  integer k;

  // code group sync interrupt: set on any loss, cleared by writing bit 7
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_irq  <= 8'h00;
      sync_prev <= 8'h00;
    end else begin
      sync_prev <= lane_alignment_flag;
      for (k = 0; k < `SLEM_LANES; k = k + 1) begin
        if (sync_prev[k] && !lane_alignment_flag[k])
          sync_irq[k] <= 1'b1;
        else if (wr_go && idx == `SLEM_IDX_SYNC && wd[`SLEM_BIT_IRQ_CLR])
          sync_irq[k] <= 1'b0;
      end
    end
  end

  // readback mux
  reg [7:0] rd_val;
  reg       rd_ok;
  always @* begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    case (idx)
      `SLEM_IDX_CNT_SEL: begin
        case (error_type_selector)
          `SLEM_TYPE_DISP:
            rd_val = disparity_error_count[{readback_lane_selector, 3'h0} +: 8];
          `SLEM_TYPE_INVALID:
            rd_val = invalid_code_count[{readback_lane_selector, 3'h0} +: 8];
          `SLEM_TYPE_UNEXP:
            rd_val = unexpected_control_count[{readback_lane_selector, 3'h0} +: 8];
          default:            rd_val = 8'h00;
        endcase
      end
      `SLEM_IDX_DESKEW:     rd_val = lane_align_enable_out;
      `SLEM_IDX_DISP:       rd_val = disparity_error_flag;
      `SLEM_IDX_INVALID:    rd_val = invalid_code_flag;
      `SLEM_IDX_UNEXP:      rd_val = unexpected_control_flag;
      `SLEM_IDX_SYNC:       rd_val = lane_alignment_flag;
      `SLEM_IDX_THRESHOLD:  rd_val = error_count_threshold;
      `SLEM_IDX_IRQ_STATUS: rd_val = sync_irq;
      `SLEM_IDX_IRQ_ENABLE: rd_val = 8'h00;
      default:              rd_ok  = 1'b0;
    endcase
  end

  // avalon handshake: one wait cycle, then answer
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state                  <= ST_IDLE;
      avs_waitrequest_out    <= 1'b1;
      avs_readdata_out       <= 32'h00000000;
      avs_response_out       <= 2'h0;
      error_type_selector    <= 2'h0;
      readback_lane_selector <= 3'h0;
      error_count_threshold  <= `SLEM_RST_THRESHOLD;
      irq_enable             <= 8'h00;
      lane_align_enable_out  <= `SLEM_RST_DESKEW;
    end else begin
      case (state)
        ST_IDLE: begin
          avs_waitrequest_out <= 1'b1;
          if (avs_read_in || avs_write_in) begin
            state               <= ST_ACK;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= avs_read_in ? {24'h000000, rd_val} : 32'h00000000;
            avs_response_out    <= rd_ok ? 2'h0 : 2'h3;
          end
          if (wr_go) begin
            case (idx)
              `SLEM_IDX_CNT_SEL: begin
                error_type_selector    <= wd[1:0];
                readback_lane_selector <= wd[6:4];
              end
              `SLEM_IDX_DESKEW:     lane_align_enable_out <= wd;
              `SLEM_IDX_THRESHOLD:  error_count_threshold <= wd;
              `SLEM_IDX_IRQ_ENABLE: irq_enable            <= wd;
              default: ;
            endcase
          end
        end
        ST_ACK: begin
          state               <= ST_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          state               <= ST_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // sync request and interrupt outputs
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_request_b_out <= 1'b0;
      irq_b_out          <= 1'b1;
    end else begin
      sync_request_b_out <= &lane_alignment_flag;
      irq_b_out <= ~((irq_enable[`SLEM_BIT_MASK_DISP] & |disparity_error_flag)
                   | (irq_enable[`SLEM_BIT_MASK_INVALID] & |invalid_code_flag)
                   | (irq_enable[`SLEM_BIT_MASK_UNEXP] & |unexpected_control_flag)
                   | (irq_enable[`SLEM_BIT_MASK_SYNC] & |sync_irq));
    end
  end

endmodule

// one error counter with its threshold flag, for one lane and one error type
module slem_err_counter (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       rst_b_in,
  // link sample and error level
  input  wire       tick_in,
  input  wire       err_in,
  // command pulses for this lane
  input  wire       clear_in,
  input  wire       stop_in,
  input  wire       irq_clear_in,
  // threshold and results
  input  wire [7:0] threshold_in,
  output reg  [7:0] count_out,
  output reg        flag_out
);

  reg stopped;

  // stop holds until reset; a clear in the same write still zeroes the count
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= 8'h00;
      stopped   <= 1'b0;
    end else begin
      if (stop_in)
        stopped <= 1'b1;
      if (clear_in)
        count_out <= 8'h00;
      else if (tick_in && err_in && !stopped && count_out != 8'hff)
        count_out <= count_out + 8'h01;
    end
  end

  // set wins over clear, so a count still at threshold keeps the flag
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      flag_out <= 1'b0;
    else if (count_out >= threshold_in)
      flag_out <= 1'b1;
    else if (irq_clear_in)
      flag_out <= 1'b0;
  end

endmodule

// ### verif/slem_checker_assertions.sv
// port-level assertions for the lane error monitor
`timescale 1ns/1ns
module slem_checker (
  // clock, reset and register bus
  input wire        ref_clk_in,
  input wire        rst_b_in,
  input wire [13:0] avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0]  avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire [1:0]  avs_response_out,
  // link side and pins
  input wire [7:0]  lane_alignment_flag_in,
  input wire [7:0]  lane_align_enable_out,
  input wire        sync_request_b_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire ack = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  property p_dsk_wr;
    ack && avs_write_in && avs_byteenable_in[0] && avs_address_in[13:2] == 12'h46c
      |-> lane_align_enable_out == avs_writedata_in[7:0];
  endproperty
  a_dsk_wr: assert property (p_dsk_wr) else $error("deskew write lost");
  property p_dsk_rst;
    $rose(rst_b_in) |-> lane_align_enable_out == 8'h0f;
  endproperty
  a_dsk_rst: assert property (p_dsk_rst) else $error("deskew reset value");
  property p_sync_lo;
    (lane_alignment_flag_in != 8'hff) [*8] |-> !sync_request_b_out;
  endproperty
  a_sync_lo: assert property (p_sync_lo) else $error("no sync request");
  property p_sync_hi;
    (lane_alignment_flag_in == 8'hff) [*8] |-> sync_request_b_out;
  endproperty
  a_sync_hi: assert property (p_sync_hi) else $error("stray sync request");
  property p_ack_one;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_upper;
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_sel_ok;
    ack && avs_address_in[13:2] == 12'h46b |-> avs_response_out == 2'b00;
  endproperty
  a_sel_ok: assert property (p_sel_ok) else $error("selector response");
endmodule
bind slem_lane_error_monitor slem_checker chk_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out), .lane_alignment_flag_in(lane_alignment_flag_in),
  .lane_align_enable_out(lane_align_enable_out), .sync_request_b_out(sync_request_b_out));

// ### verif/slem_tx_model.sv
// transmitter model: link clock, per-lane error levels and lane alignment
`timescale 1ns/1ns
module slem_tx_model (
  input  wire       sync_req_b_in,
  output reg        link_clk_out,
  output reg  [7:0] disp_out,
  output reg  [7:0] inv_out,
  output reg  [7:0] ucc_out,
  output reg  [7:0] align_out
);
  initial {link_clk_out, disp_out, inv_out, ucc_out, align_out} = {1'b0, 24'h0, 8'hff};
  // n code groups of error type k on lanes m; link clock stands still outside
  task send(input [1:0] k, input [7:0] m, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      disp_out = (k == 2'h0) ? m : 8'h0;
      inv_out = (k == 2'h1) ? m : 8'h0;
      ucc_out = (k == 2'h2) ? m : 8'h0;
      #62 link_clk_out = 1'b1;
      #63 link_clk_out = 1'b0;
    end
    {disp_out, inv_out, ucc_out} = 24'h0;
    #125;
  endtask
  task drop(input [2:0] l);
    align_out[l] = 1'b0;
    wait (sync_req_b_in === 1'b0);
  endtask
  // alignment restarts only once the request is seen
  task realign;
    if (sync_req_b_in === 1'b0) align_out = 8'hff;
  endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the lane error monitor
`timescale 1ns/1ns
`include "slem_map.vh"
module tb_top;
  reg         clk, rst_b, rd, wr;
  reg  [13:0] adr;
  reg  [31:0] wd, q;
  reg  [1:0]  qr;
  wire [31:0] rdat;
  wire [1:0]  resp;
  wire        wt, lclk, sreq_b, irq_b;
  wire [7:0]  de, ic, uc, al, dsk;
  integer     n_errors = 0, checks = 0, cyc = 0;
  slem_lane_error_monitor dut_u (.ref_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .avs_response_out(resp),
    .link_clk_in(lclk), .disparity_error_in(de), .invalid_code_in(ic),
    .unexpected_control_in(uc), .lane_alignment_flag_in(al), .lane_align_enable_out(dsk),
    .sync_request_b_out(sreq_b), .irq_b_out(irq_b));
  slem_tx_model tx_u (.sync_req_b_in(sreq_b), .link_clk_out(lclk), .disp_out(de),
    .inv_out(ic), .ucc_out(uc), .align_out(al));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input [8*12:1] nm, input [31:0] s, input [31:0] e);
    checks = checks + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0s exp %h seen %h", nm, e, s);
    end
  endtask
  task bus(input w, input [11:0] i, input [7:0] d);
    @(posedge clk);
    adr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    @(posedge clk);
    while (wt !== 1'b0) @(posedge clk);
    q = rdat;
    qr = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rc(input [8*12:1] nm, input [11:0] i, input [31:0] e);
    bus(1'b0, i, 8'h0);
    chk(nm, q, e);
  endtask
  task t_reset;
    chk("deskew_pin", {24'h0, dsk}, 32'h0f);
    rc("deskew_reg", `SLEM_IDX_DESKEW, 32'h0f);
    bus(1'b1, `SLEM_IDX_DESKEW, 8'ha5);
    chk("deskew_wr", {24'h0, dsk}, 32'ha5);
    bus(1'b0, 12'h400, 8'h0);
    chk("unmapped", {q[29:0], qr}, 32'h3);
    $display("test reset done");
  endtask
  task t_err(input [1:0] k);
    reg [11:0] a;
    a = `SLEM_IDX_DISP + k;
    bus(1'b1, `SLEM_IDX_CNT_SEL, {1'b0, 3'h5, 2'h0, k});
    tx_u.send(k, 8'h20, 3);
    rc("count", `SLEM_IDX_CNT_SEL, 32'h3);
    rc("flag_below", a, 32'h0);
    tx_u.send(k, 8'h20, 1);
    rc("flag_at", a, 32'h20);
    chk("irq_low", {31'h0, irq_b}, 32'h0);
    bus(1'b1, a, 8'h25);
    rc("count_clr", `SLEM_IDX_CNT_SEL, 32'h0);
    bus(1'b1, a, 8'h85);
    rc("flag_clr", a, 32'h0);
    chk("irq_high", {31'h0, irq_b}, 32'h1);
    tx_u.send(k, 8'h21, 1);
    rc("after_pulse", `SLEM_IDX_CNT_SEL, 32'h1);
    bus(1'b1, a, 8'h45);
    tx_u.send(k, 8'h20, 2);
    rc("stopped", `SLEM_IDX_CNT_SEL, 32'h1);
    bus(1'b1, `SLEM_IDX_CNT_SEL, {6'h0, k});
    rc("lane0", `SLEM_IDX_CNT_SEL, 32'h1);
    $display("test errors done");
  endtask
  task t_sync;
    rc("sync_ok", `SLEM_IDX_SYNC, 32'hff);
    tx_u.drop(3'h2);
    rc("sync_lost", `SLEM_IDX_SYNC, 32'hfb);
    chk("request", {31'h0, sreq_b}, 32'h0);
    bus(1'b0, `SLEM_IDX_IRQ_STATUS, 8'h0);
    chk("sync_irq", {31'h0, |q}, 32'h1);
    tx_u.realign;
    bus(1'b1, `SLEM_IDX_SYNC, 8'h80);
    rc("sync_irq_clr", `SLEM_IDX_IRQ_STATUS, 32'h0);
    repeat (8) @(posedge clk);
    rc("sync_back", `SLEM_IDX_SYNC, 32'hff);
    chk("request_off", {31'h0, sreq_b}, 32'h1);
    $display("test sync done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst_b, rd, wr, adr, wd} = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    bus(1'b1, `SLEM_IDX_THRESHOLD, 8'h04);
    bus(1'b1, `SLEM_IDX_IRQ_ENABLE, 8'he0);
    t_err(2'h0);
    t_err(2'h1);
    t_err(2'h2);
    t_sync;
    final_report;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
endmodule
